// ===== dv/tb.sv
// self-checking bench for the write guard
// assumes the host model drives all command traffic at falling edges
`timescale 1ns/1ps
module tb;
    logic sys_clk = 1'h0;
    logic rstn = 1'h0;
    logic write_protect_pin = 1'h0;
    logic [1:0] addr_select_hi = 2'h0;
    logic [1:0] addr_select_lo = 2'h0;
    logic addr_valid = 1'h0;
    logic [6:0] addr_byte = 7'h0;
    logic cmd_wr_valid, cmd_rd_valid, addr_ack, cmd_accept, cmd_reject, cml_fault, rd_known;
    wgp_pkg::wgp_cmd_t cmd_wr;
    logic [7:0] cmd_rd_code, rd_data, page_out, chan_wr_en, lk, d;
    logic [6:0] dev_addr, ea;
    wgp_pkg::wgp_level_t eff_level, el;
    logic [10:0] res;
    logic [8:0] rres;
    logic ok;
    int err_total = 0;
    int tests_run = 0;
    logic [7:0] locks [3] = '{wgp_pkg::LOCK_NONE, wgp_pkg::LOCK_LEVEL_TWO,
                              wgp_pkg::LOCK_LEVEL_ONE};
    // first four pass level one, first eight pass level two
    logic [7:0] cmds [10] = '{wgp_pkg::CMD_WRITE_LOCK, wgp_pkg::CMD_PAGE,
        wgp_pkg::CMD_EEPROM_UNLOCK, wgp_pkg::CMD_STORE_USER_ALL, wgp_pkg::CMD_OPERATION,
        wgp_pkg::CMD_COMMAND_PLUS, wgp_pkg::CMD_GLOBAL_MASK, wgp_pkg::CMD_CLEAR_FAULTS,
        wgp_pkg::CMD_ON_OFF_CONFIG, wgp_pkg::CMD_BASE_ADDR};
    localparam logic [10:0] ACC = 11'h400;
    localparam logic [10:0] REJ = 11'h200;

    always #20 sys_clk = ~sys_clk;

    wgp_guard u_wgp_guard (.sys_clk, .rstn, .write_protect_pin, .addr_select_hi,
        .addr_select_lo, .cmd_wr_valid, .cmd_wr, .cmd_rd_valid, .cmd_rd_code, .addr_valid,
        .addr_byte, .addr_ack, .dev_addr, .cmd_accept, .cmd_reject, .cml_fault, .chan_wr_en,
        .rd_data, .rd_known, .page_out, .eff_level);

    wgp_host_model u_wgp_host_model (.sys_clk, .cmd_wr_valid, .cmd_wr, .cmd_rd_valid,
        .cmd_rd_code, .cmd_accept, .cmd_reject, .cml_fault, .chan_wr_en, .rd_data, .rd_known);

    // ==========================================
    // compare and access tasks
    task automatic chk(input logic [10:0] got, input logic [10:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic wr_chk(input logic [7:0] c, input logic [7:0] dd, input logic p,
                          input logic [10:0] e);
        u_wgp_host_model.wr(c, dd, p, res);
        chk(res, e, "write response");
    endtask

    task automatic rd_chk(input logic [7:0] c, input logic [7:0] e, input logic k);
        u_wgp_host_model.rd(c, rres);
        chk(11'(rres), {2'h0, k, e}, "read");
    endtask

    task automatic addr_chk(input logic [6:0] b, input logic e);
        @(negedge sys_clk);
        addr_valid = 1'h1;
        addr_byte = b;
        @(negedge sys_clk);
        chk(11'(addr_ack), 11'(e), "address ack");
        addr_valid = 1'h0;
    endtask

    task automatic complete_run;
        if (err_total == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // hang guard: well beyond the few hundred cycles the sequence needs
    initial begin
        repeat (20000) @(posedge sys_clk);
        err_total++;
        complete_run();
    end

    // ==========================================
    // main sequence
    initial begin
        repeat (20) @(negedge sys_clk);
        rstn = 1'h1;
        repeat (4) @(negedge sys_clk);
        rd_chk(wgp_pkg::CMD_BASE_ADDR, 8'h5C, 1'h1);
        rd_chk(wgp_pkg::CMD_WRITE_LOCK, 8'h00, 1'h1);
        chk(11'(page_out), 11'h0, "page");
        rd_chk(8'h77, 8'h00, 1'h0);
        for (int h = 0; h < 3; h++) begin
            for (int o = 0; o < 3; o++) begin
                addr_select_hi = h[1:0];
                addr_select_lo = o[1:0];
                repeat (5) @(negedge sys_clk);
                ea = 7'h5C + 7'(3 * h + o);
                chk(11'(dev_addr), 11'(ea), "device address");
                addr_chk(ea, 1'h1);
                addr_chk(ea + 7'h1, 1'h0);
            end
        end
        wr_chk(wgp_pkg::CMD_BASE_ADDR, 8'hA0, 1'h0, ACC);
        rd_chk(wgp_pkg::CMD_BASE_ADDR, 8'h20, 1'h1);
        repeat (2) @(negedge sys_clk);
        chk(11'(dev_addr), 11'h28, "device address");
        wr_chk(wgp_pkg::CMD_BASE_ADDR, 8'h5C, 1'h0, ACC);
        for (int p = 0; p < 2; p++) begin
            write_protect_pin = p[0];
            repeat (3) @(negedge sys_clk);
            foreach (locks[l]) begin
                lk = locks[l];
                wr_chk(wgp_pkg::CMD_WRITE_LOCK, lk, 1'h0, ACC);
                el = (lk == 8'h80) ? wgp_pkg::WGP_LVL_ONE :
                    (lk == 8'h40 || p == 1) ? wgp_pkg::WGP_LVL_TWO : wgp_pkg::WGP_LVL_NONE;
                chk(11'(eff_level), 11'(el), "level");
                foreach (cmds[i]) begin
                    ok = i < 4 || (i < 8 && lk != 8'h80) || el == wgp_pkg::WGP_LVL_NONE;
                    d = (i == 0) ? lk : (i == 6) ? 8'hFF : (i == 9) ? 8'h5C : 8'h00;
                    wr_chk(cmds[i], d, 1'h0, ok ? ACC : REJ);
                end
                rd_chk(wgp_pkg::CMD_GLOBAL_MASK, 8'hFF, 1'h1);
            end
        end
        wr_chk(wgp_pkg::CMD_BASE_ADDR, 8'h11, 1'h0, REJ);
        rd_chk(wgp_pkg::CMD_BASE_ADDR, 8'h5C, 1'h1);
        wr_chk(wgp_pkg::CMD_WRITE_LOCK, 8'h20, 1'h0, REJ);
        rd_chk(wgp_pkg::CMD_WRITE_LOCK, 8'h80, 1'h1);
        write_protect_pin = 1'h0;
        wr_chk(wgp_pkg::CMD_WRITE_LOCK, 8'h00, 1'h0, ACC);
        repeat (3) @(negedge sys_clk);
        wr_chk(wgp_pkg::CMD_GLOBAL_MASK, 8'hA5, 1'h0, ACC);
        wr_chk(wgp_pkg::CMD_PAGE, 8'hFF, 1'h0, ACC);
        for (int c = 1; c < 4; c++) begin
            wr_chk(8'(c), 8'h00, 1'h1, ACC | 11'hA5);
        end
        wr_chk(wgp_pkg::CMD_COMMAND_PLUS, 8'h00, 1'h1, REJ | 11'h100);
        wr_chk(wgp_pkg::CMD_GLOBAL_MASK, 8'h00, 1'h0, ACC);
        wr_chk(wgp_pkg::CMD_CLEAR_FAULTS, 8'h00, 1'h1, ACC);
        wr_chk(wgp_pkg::CMD_PAGE, 8'h03, 1'h0, ACC);
        wr_chk(wgp_pkg::CMD_OPERATION, 8'h00, 1'h1, ACC | 11'h08);
        complete_run();
    end
endmodule

// ===== dv/wgp_host_model.sv
// host model issuing decoded command writes and reads to the guard
// assumes the guard samples requests on the rising edge of sys_clk
`timescale 1ns/1ps
module wgp_host_model (
    input wire logic sys_clk,
    output logic cmd_wr_valid,
    output wgp_pkg::wgp_cmd_t cmd_wr,
    output logic cmd_rd_valid,
    output logic [7:0] cmd_rd_code,
    input wire logic cmd_accept,
    input wire logic cmd_reject,
    input wire logic cml_fault,
    input wire logic [7:0] chan_wr_en,
    input wire logic [7:0] rd_data,
    input wire logic rd_known
);
    // ==========================================
    // requests
    initial begin
        cmd_wr_valid = 1'h0;
        cmd_wr = 17'h0;
        cmd_rd_valid = 1'h0;
        cmd_rd_code = 8'h0;
    end

    // idle payload is inverted so a stale value never passes for a request
    task automatic wr(input logic [7:0] c, input logic [7:0] d, input logic p,
                      output logic [10:0] res);
        @(negedge sys_clk);
        cmd_wr_valid = 1'h1;
        cmd_wr = '{code: c, data: d, paged: p};
        @(negedge sys_clk);
        // the answer stands for one cycle only, so take it before it drops
        res = {cmd_accept, cmd_reject, cml_fault, chan_wr_en};
        cmd_wr_valid = 1'h0;
        cmd_wr = ~cmd_wr;
    endtask

    task automatic rd(input logic [7:0] c, output logic [8:0] res);
        @(negedge sys_clk);
        cmd_rd_valid = 1'h1;
        cmd_rd_code = c;
        @(negedge sys_clk);
        cmd_rd_valid = 1'h0;
        cmd_rd_code = ~cmd_rd_code;
        @(negedge sys_clk);
        res = {rd_known, rd_data};
    endtask
endmodule

// ===== src/wgp_guard.sv
// write guard, global page mask and bus address former
// assumes a command front end delivering decoded writes and reads on sys_clk
`timescale 1ns/1ps
module wgp_guard #(
    parameter int CHANNELS = 8
) (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic write_protect_pin,
    input wire logic [1:0] addr_select_hi,
    input wire logic [1:0] addr_select_lo,
    input wire logic cmd_wr_valid,
    input wire wgp_pkg::wgp_cmd_t cmd_wr,
    input wire logic cmd_rd_valid,
    input wire logic [7:0] cmd_rd_code,
    input wire logic addr_valid,
    input wire logic [6:0] addr_byte,
    output logic addr_ack,
    output logic [6:0] dev_addr,
    output logic cmd_accept,
    output logic cmd_reject,
    output logic cml_fault,
    output logic [CHANNELS-1:0] chan_wr_en,
    output logic [7:0] rd_data,
    output logic rd_known,
    output logic [7:0] page_out,
    output wgp_pkg::wgp_level_t eff_level
);
    // ==========================================================
    // pin synchronisers
    logic wp_sync;
    logic [3:0] sel_sync;

    wgp_sync #(.WIDTH(1)) u_wp_sync (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .pin_in(write_protect_pin),
        .pin_sync(wp_sync)
    );

    wgp_sync #(.WIDTH(4)) u_sel_sync (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .pin_in({addr_select_hi, addr_select_lo}),
        .pin_sync(sel_sync)
    );

    // ==========================================================
    // registers
    logic [7:0] lock_reg;
    logic [7:0] lock_next;
    logic [7:0] mask_reg;
    logic [7:0] mask_next;
    logic [7:0] page_reg;
    logic [7:0] page_next;
    logic [6:0] base_reg;
    logic [6:0] base_next;
    logic [6:0] dev_addr_reg;
    logic accept_reg;
    logic reject_reg;
    logic cml_reg;
    logic [CHANNELS-1:0] chan_reg;
    logic [CHANNELS-1:0] chan_next;
    logic [7:0] rd_data_reg;
    logic [7:0] rd_data_next;
    logic rd_known_reg;
    logic rd_known_next;

    // ==========================================================
    // command decode
    wire is_lock = cmd_wr.code == wgp_pkg::CMD_WRITE_LOCK;
    wire is_page = cmd_wr.code == wgp_pkg::CMD_PAGE;
    wire is_unlock = cmd_wr.code == wgp_pkg::CMD_EEPROM_UNLOCK;
    wire is_store = cmd_wr.code == wgp_pkg::CMD_STORE_USER_ALL;
    wire is_oper = cmd_wr.code == wgp_pkg::CMD_OPERATION;
    wire is_onoff = cmd_wr.code == wgp_pkg::CMD_ON_OFF_CONFIG;
    wire is_cplus = cmd_wr.code == wgp_pkg::CMD_COMMAND_PLUS;
    wire is_mask = cmd_wr.code == wgp_pkg::CMD_GLOBAL_MASK;
    wire is_clear = cmd_wr.code == wgp_pkg::CMD_CLEAR_FAULTS;
    wire is_base = cmd_wr.code == wgp_pkg::CMD_BASE_ADDR;

    wire level_one_ok = is_lock | is_page | is_unlock | is_store;
    wire level_two_ok = level_one_ok | is_oper | is_cplus | is_mask | is_clear;

    // ==========================================================
    // effective protection level
    wire lock_is_one = lock_reg == wgp_pkg::LOCK_LEVEL_ONE;
    wire lock_is_two = lock_reg == wgp_pkg::LOCK_LEVEL_TWO;
    wire wgp_pkg::wgp_level_t level_w = lock_is_one ? wgp_pkg::WGP_LVL_ONE :
        (lock_is_two | wp_sync) ? wgp_pkg::WGP_LVL_TWO :
        wgp_pkg::WGP_LVL_NONE;

    wire permit = (level_w == wgp_pkg::WGP_LVL_NONE) ? 1'b1 :
        (level_w == wgp_pkg::WGP_LVL_TWO) ? level_two_ok : level_one_ok;

    // reserved lock codes are refused so the level decode never sees them
    wire lock_code_ok = (cmd_wr.data == wgp_pkg::LOCK_NONE) |
        (cmd_wr.data == wgp_pkg::LOCK_LEVEL_TWO) |
        (cmd_wr.data == wgp_pkg::LOCK_LEVEL_ONE);
    wire lock_bad = is_lock & ~lock_code_ok;

    // ==========================================================
    // global page handling
    wire page_global = page_reg == wgp_pkg::PAGE_GLOBAL;
    wire global_capable = is_oper | is_onoff | is_clear;
    wire global_bad = cmd_wr.paged & page_global & ~global_capable;
    wire page_in_range = page_reg <= wgp_pkg::PAGE_LAST;

    wire accept_w = cmd_wr_valid & permit & ~global_bad & ~lock_bad;
    wire reject_w = cmd_wr_valid & ~accept_w;

    logic [CHANNELS-1:0] page_onehot;
    genvar gi;
    generate
        for (gi = 0; gi < CHANNELS; gi++) begin : g_chan
            // a masked-out channel ignores global page writes
            assign page_onehot[gi] = page_global ? mask_reg[gi] :
                (page_in_range & (page_reg[2:0] == 3'(gi)));
        end
    endgenerate

    localparam int BASE_MSB_W = wgp_pkg::BASE_MSB;

    // blocked writes leave lock, mask, page and base alone and raise no channel strobe
    assign lock_next = (accept_w & is_lock) ? cmd_wr.data : lock_reg;
    assign mask_next = (accept_w & is_mask) ? cmd_wr.data : mask_reg;
    assign page_next = (accept_w & is_page) ? cmd_wr.data : page_reg;
    assign base_next = (accept_w & is_base) ? cmd_wr.data[BASE_MSB_W:0] : base_reg;
    assign chan_next = (accept_w & cmd_wr.paged) ? page_onehot : '0;

    // ==========================================================
    // bus address
    // pins read low, float or high; a code of 3 is treated as high
    wire [1:0] sel_hi = (sel_sync[3:2] > wgp_pkg::SEL_HIGH) ? wgp_pkg::SEL_HIGH : sel_sync[3:2];
    wire [1:0] sel_lo = (sel_sync[1:0] > wgp_pkg::SEL_HIGH) ? wgp_pkg::SEL_HIGH : sel_sync[1:0];
    wire [3:0] sel_offset = 4'(wgp_pkg::SEL_WEIGHT_HI * {2'h0, sel_hi}) + {2'h0, sel_lo};
    wire [6:0] dev_addr_w = 7'(base_reg + {3'h0, sel_offset});

    assign addr_ack = addr_valid & (addr_byte == dev_addr_reg);

    // ==========================================================
    // read path, never gated by protection
    always_comb begin
        rd_data_next = 8'h00;
        rd_known_next = 1'b1;
        case (cmd_rd_code)
            wgp_pkg::CMD_WRITE_LOCK: begin
                rd_data_next = lock_reg;
            end
            wgp_pkg::CMD_GLOBAL_MASK: begin
                rd_data_next = mask_reg;
            end
            wgp_pkg::CMD_PAGE: begin
                rd_data_next = page_reg;
            end
            wgp_pkg::CMD_BASE_ADDR: begin
                rd_data_next = {1'b0, base_reg};
            end
            default: begin
                rd_known_next = 1'b0;
            end
        endcase
    end

    // ==========================================================
    // state
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            lock_reg <= wgp_pkg::RST_WRITE_LOCK;
            mask_reg <= wgp_pkg::RST_GLOBAL_MASK;
            page_reg <= wgp_pkg::RST_PAGE;
            base_reg <= wgp_pkg::RST_BASE_ADDR;
        end else begin
            lock_reg <= lock_next;
            mask_reg <= mask_next;
            page_reg <= page_next;
            base_reg <= base_next;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            accept_reg <= 1'b0;
            reject_reg <= 1'b0;
            cml_reg <= 1'b0;
            chan_reg <= '0;
            dev_addr_reg <= wgp_pkg::RST_BASE_ADDR;
        end else begin
            accept_reg <= accept_w;
            reject_reg <= reject_w;
            cml_reg <= cmd_wr_valid & global_bad;
            chan_reg <= chan_next;
            dev_addr_reg <= dev_addr_w;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            rd_data_reg <= 8'h00;
            rd_known_reg <= 1'b0;
        end else if (cmd_rd_valid) begin
            rd_data_reg <= rd_data_next;
            rd_known_reg <= rd_known_next;
        end
    end

    assign dev_addr = dev_addr_reg;
    assign cmd_accept = accept_reg;
    assign cmd_reject = reject_reg;
    assign cml_fault = cml_reg;
    assign chan_wr_en = chan_reg;
    assign rd_data = rd_data_reg;
    assign rd_known = rd_known_reg;
    assign page_out = page_reg;
    assign eff_level = level_w;

    // ==========================================================
    // checks
    a_level_one_block: assert property (@(posedge sys_clk) disable iff (!rstn)
        (cmd_wr_valid && lock_reg == wgp_pkg::LOCK_LEVEL_ONE && is_oper)
        |=> (cmd_reject && !cmd_accept && chan_wr_en == '0))
        else $error("level one let a channel write through");

    a_level_two_pass: assert property (@(posedge sys_clk) disable iff (!rstn)
        (cmd_wr_valid && lock_reg == wgp_pkg::LOCK_LEVEL_TWO && is_clear && !global_bad)
        |=> cmd_accept)
        else $error("level two refused an excepted command");

    a_no_lock_open: assert property (@(posedge sys_clk) disable iff (!rstn)
        (cmd_wr_valid && lock_reg == wgp_pkg::LOCK_NONE && !wp_sync && !global_bad && !lock_bad)
        |=> cmd_accept)
        else $error("unlocked write refused");

    a_pin_forces_two: assert property (@(posedge sys_clk) disable iff (!rstn)
        (cmd_wr_valid && wp_sync && is_base) |=> (cmd_reject && $stable(base_reg)))
        else $error("protect pin did not block base write");

    a_stricter_wins: assert property (@(posedge sys_clk) disable iff (!rstn)
        (wp_sync && lock_reg == wgp_pkg::LOCK_LEVEL_ONE) |-> eff_level == wgp_pkg::WGP_LVL_ONE)
        else $error("pin lowered a level one lock");

    a_mask_gates_chan: assert property (@(posedge sys_clk) disable iff (!rstn)
        (accept_w && cmd_wr.paged && page_global) |=> (chan_wr_en == $past(mask_reg)))
        else $error("global page strobe does not follow mask");

    a_global_fault: assert property (@(posedge sys_clk) disable iff (!rstn)
        (cmd_wr_valid && cmd_wr.paged && page_global && !global_capable)
        |=> (cml_fault && cmd_reject && !cmd_accept && $stable(base_reg)))
        else $error("unsupported global write not faulted");

    a_base_rsvd_zero: assert property (@(posedge sys_clk) disable iff (!rstn)
        (cmd_rd_valid && cmd_rd_code == wgp_pkg::CMD_BASE_ADDR) |=> (rd_data[7] == 1'b0))
        else $error("base reserved bit read as one");

    a_addr_offset: assert property (@(posedge sys_clk) disable iff (!rstn)
        (sel_sync == 4'hA && $stable(base_reg)) |=> (dev_addr == 7'($past(base_reg) + 7'h08)))
        else $error("both selects high did not add eight");

    // ==========================================================
    // reads, refused writes and strobe shape
    a_read_unguarded: assert property (@(posedge sys_clk) disable iff (!rstn)
        (cmd_rd_valid && cmd_rd_code == wgp_pkg::CMD_WRITE_LOCK)
        |=> (rd_known && rd_data == $past(lock_reg)))
        else $error("lock read not answered");

    a_refused_inert: assert property (@(posedge sys_clk) disable iff (!rstn)
        reject_w |=> ($stable(lock_reg) && $stable(mask_reg) && $stable(page_reg)
            && $stable(base_reg) && chan_wr_en == '0))
        else $error("refused write changed state");

    a_page_one_chan: assert property (@(posedge sys_clk) disable iff (!rstn)
        (accept_w && cmd_wr.paged && page_reg <= wgp_pkg::PAGE_LAST) |=> $onehot(chan_wr_en))
        else $error("single page write did not strobe one channel");

    a_pin_level_two: assert property (@(posedge sys_clk) disable iff (!rstn)
        (wp_sync && lock_reg != wgp_pkg::LOCK_LEVEL_ONE) |-> eff_level == wgp_pkg::WGP_LVL_TWO)
        else $error("protect pin did not give level two");

    // reserved codes are refused, so the level decode never meets one
    a_lock_code_legal: assert property (@(posedge sys_clk) disable iff (!rstn)
        (lock_reg == wgp_pkg::LOCK_NONE || lock_reg == wgp_pkg::LOCK_LEVEL_TWO
            || lock_reg == wgp_pkg::LOCK_LEVEL_ONE))
        else $error("lock register holds a reserved code");

    a_fault_refused: assert property (@(posedge sys_clk) disable iff (!rstn)
        cml_fault |-> (cmd_reject && !cmd_accept))
        else $error("fault raised on an accepted write");

    a_addr_mismatch: assert property (@(posedge sys_clk) disable iff (!rstn)
        (addr_valid && addr_byte != dev_addr) |-> !addr_ack)
        else $error("address acknowledged on mismatch");
endmodule

// ===== src/wgp_pkg.sv
// package for the write guard and global page mask block
// assumes a command front end that has already decoded the bus protocol
package wgp_pkg;

    // command codes seen by the guard
    localparam logic [7:0] CMD_PAGE = 8'h00;
    localparam logic [7:0] CMD_OPERATION = 8'h01;
    localparam logic [7:0] CMD_ON_OFF_CONFIG = 8'h02;
    localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
    localparam logic [7:0] CMD_WRITE_LOCK = 8'h10;
    localparam logic [7:0] CMD_STORE_USER_ALL = 8'h15;
    localparam logic [7:0] CMD_EEPROM_UNLOCK = 8'hBD;
    localparam logic [7:0] CMD_COMMAND_PLUS = 8'hBE;
    localparam logic [7:0] CMD_GLOBAL_MASK = 8'hE4;
    localparam logic [7:0] CMD_BASE_ADDR = 8'hE6;

    // write lock level codes
    localparam logic [7:0] LOCK_NONE = 8'h00;
    localparam logic [7:0] LOCK_LEVEL_TWO = 8'h40;
    localparam logic [7:0] LOCK_LEVEL_ONE = 8'h80;

    // page values
    localparam logic [7:0] PAGE_GLOBAL = 8'hFF;
    localparam logic [7:0] PAGE_LAST = 8'h07;

    // reset values
    localparam logic [7:0] RST_WRITE_LOCK = 8'h00;
    localparam logic [7:0] RST_GLOBAL_MASK = 8'hFF;
    localparam logic [7:0] RST_PAGE = 8'h00;
    localparam logic [6:0] RST_BASE_ADDR = 7'h5C;

    // field layout of the base address register
    localparam int BASE_MSB = 6;
    localparam int BASE_RSVD_BIT = 7;

    // address select pin levels, two bits per pin
    localparam logic [1:0] SEL_LOW = 2'h0;
    localparam logic [1:0] SEL_FLOAT = 2'h1;
    localparam logic [1:0] SEL_HIGH = 2'h2;
    localparam logic [3:0] SEL_WEIGHT_HI = 4'h3;

    typedef enum logic [1:0] {
        WGP_LVL_NONE = 2'b00,
        WGP_LVL_TWO = 2'b01,
        WGP_LVL_ONE = 2'b11
    } wgp_level_t;

    typedef struct packed {
        logic [7:0] code;
        logic [7:0] data;
        logic paged;
    } wgp_cmd_t;

endpackage

// ===== src/wgp_sync.sv
// two flop synchroniser for pin inputs
// assumes pins are quasi static relative to sys_clk
`timescale 1ns/1ps
module wgp_sync #(
    parameter int WIDTH = 1
) (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0] pin_sync
);
    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] sync_reg;

    // first stage feeds only the second stage
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            meta_reg <= '0;
            sync_reg <= '0;
        end else begin
            meta_reg <= pin_in;
            sync_reg <= meta_reg;
        end
    end

    assign pin_sync = sync_reg;
endmodule
